// ### rtl/sarcc_cfg.svh
`ifndef SARCC_CFG_SVH
`define SARCC_CFG_SVH
// code width and one code step is reference / 65536
`define SARCC_CODE_W 16
`define SARCC_CODE_STEPS 65536
// straight binary end codes
`define SARCC_SB_FULL 16'hffff
`define SARCC_SB_ZERO 16'h0000
// twos complement end codes and the sign bit flip between formats
`define SARCC_TC_FULL 16'h7fff
`define SARCC_TC_ZERO 16'h8000
`define SARCC_SIGN_FLIP 16'h8000
// conversion phase length in ns at the 50 ns clock
`define SARCC_CLK_NS 50
`define SARCC_CONV_NS 1500
`define SARCC_CONV_CYC ((`SARCC_CONV_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)
// self-run acquisition interval in low-power mode, in ns
`define SARCC_ACQ_NS 250
`define SARCC_ACQ_CYC ((`SARCC_ACQ_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)
// counter width
`define SARCC_CNT_W 8
// mode encodings
`define SARCC_MODE_FAST 2'h0
`define SARCC_MODE_NORMAL 2'h1
`define SARCC_MODE_LOWPWR 2'h2
`endif

// ### rtl/sarcc_pkg.sv
`include "sarcc_cfg.svh"
package sarcc_pkg;
    // operating mode of the converter
    typedef enum logic [1:0]
    {
        SARCC_FAST = 2'h0,
        SARCC_NORMAL = 2'h1,
        SARCC_LOWPWR = 2'h2
    } sarcc_mode_e;
    // conversion control states
    typedef enum logic [1:0]
    {
        SARCC_IDLE = 2'h0,
        SARCC_CONV = 2'h1,
        SARCC_ACQ = 2'h2
    } sarcc_state_e;
    // result code type
    typedef logic [`SARCC_CODE_W-1:0] sarcc_code_t;
endpackage

// ### rtl/sarcc_sync.sv
`include "sarcc_cfg.svh"
// three-stage synchroniser with agreement filter for one pin
module sarcc_sync
    import sarcc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic pin_in,
    output logic level_out
);
    logic s1_q; // metastable stage, read only by s2
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;
    // change accepted once stages two and three agree
    always_comb
    begin
        lvl_d = lvl_q;
        if (s2_q == s3_q)
        begin
            lvl_d = s3_q;
        end
    end
    // reset takes constants only; idle level is high for an active-low pin
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            lvl_q <= 1'b1;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end
    assign level_out = lvl_q;
endmodule

// ### rtl/sarcc_top.sv
`include "sarcc_cfg.svh"
// Summary of operation
// [RULE1] only the start pin begins conversions
// [RULE2] running conversion never restarted or aborted
// [RULE3] low-power: start low at busy end retriggers
// [RULE4] low-power: held start keeps conversions running back-to-back
// [RULE5] host pulls start low once after power-up
// [RULE6] self-run only in low-power mode
// [RULE7] overrange input gives full-scale code
// [RULE8] underrange input gives zero-scale code
// [RULE9] low-power enters reduced power after conversion
// [RULE10] interface and reference stay on while acquiring
// [RULE11] two static pins choose the reference source
// [RULE12] start falling edge begins conversion, busy ends it
// [RULE13] format pin picks binary or twos complement
// [RULE14] host discards stale first result in fast mode
// [RULE15] start requests during busy are dropped
module sarcc_top
    import sarcc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic conv_start_n_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic full_powerdown_in,
    input wire logic [1:0] mode_in,
    input wire logic internal_ref_off_in,
    input wire logic ref_buffer_off_in,
    input wire logic code_format_select_in,
    input wire logic [`SARCC_CODE_W-1:0] sample_code_in,
    input wire logic sample_over_in,
    input wire logic sample_under_in,
    output logic busy_out,
    output logic [`SARCC_CODE_W-1:0] result_out,
    output logic result_valid_out,
    output logic low_power_idle_out,
    output logic int_ref_enable_out,
    output logic ref_buffer_enable_out,
    output logic interface_enable_out,
    output logic core_powered_out
);
    logic start_lvl; // filtered start pin level
    logic start_prev_q; // previous filtered level, for edge detect
    logic start_prev_d;
    sarcc_state_e state_q;
    sarcc_state_e state_d;
    logic [`SARCC_CNT_W-1:0] cnt_q;
    logic [`SARCC_CNT_W-1:0] cnt_d;
    logic busy_q;
    logic busy_d;
    sarcc_code_t result_q;
    sarcc_code_t result_d;
    logic valid_q;
    logic valid_d;
    logic lp_idle_q;
    logic lp_idle_d;
    logic iref_q;
    logic iref_d;
    logic rbuf_q;
    logic rbuf_d;
    logic ifen_q;
    logic ifen_d;
    logic core_q;
    logic core_d;
    logic start_fall; // one-cycle falling edge of the start pin
    logic self_run; // low-power mode selected

    // start pin comes from the host domain; chip select and read are not consulted
    sarcc_sync u_start_sync
    (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(conv_start_n_in),
        .level_out(start_lvl)
    );

    // saturate and format the captured code; called once, when a conversion ends
    function automatic sarcc_code_t fmt_code(input sarcc_code_t raw, input logic over,
                                             input logic under, input logic sb);
        sarcc_code_t c;
        c = raw;
        // [RULE7] overrange clamps high
        if (over)
        begin
            c = `SARCC_SB_FULL;
        end
        // [RULE8] underrange clamps low
        else if (under)
        begin
            c = `SARCC_SB_ZERO;
        end
        // [RULE13] twos complement flips sign
        if (!sb)
        begin
            c = c ^ `SARCC_SIGN_FLIP;
        end
        return c;
    endfunction

    // [RULE1] edge of start only
    assign start_fall = start_prev_q & ~start_lvl;
    // [RULE6] self-run in low-power
    assign self_run = (mode_in == `SARCC_MODE_LOWPWR);

    // conversion control next state
    always_comb
    begin
        start_prev_d = start_lvl;
        state_d = state_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        result_d = result_q;
        valid_d = 1'b0;
        lp_idle_d = lp_idle_q;
        case (state_q)
            SARCC_IDLE:
            begin
                // [RULE12] falling edge starts conversion
                if (start_fall)
                begin
                    state_d = SARCC_CONV;
                    cnt_d = `SARCC_CNT_W'(`SARCC_CONV_CYC - 1);
                    busy_d = 1'b1;
                    lp_idle_d = 1'b0;
                end
            end
            SARCC_CONV:
            begin
                // [RULE2] powerdown and start ignored here
                // [RULE15] no queuing while busy
                if (cnt_q != '0)
                begin
                    cnt_d = cnt_q - `SARCC_CNT_W'(1);
                end
                else
                begin
                    busy_d = 1'b0;
                    valid_d = 1'b1;
                    result_d = fmt_code(sample_code_in, sample_over_in,
                                        sample_under_in, code_format_select_in);
                    // [RULE9] reduced power after conversion
                    lp_idle_d = self_run;
                    // [RULE3] retrigger if start held low
                    if (self_run && !start_lvl)
                    begin
                        state_d = SARCC_ACQ;
                        cnt_d = `SARCC_CNT_W'(`SARCC_ACQ_CYC - 1);
                    end
                    else
                    begin
                        state_d = SARCC_IDLE;
                    end
                end
            end
            SARCC_ACQ:
            begin
                // device-timed acquisition; released start aborts self-run
                if (start_lvl)
                begin
                    state_d = SARCC_IDLE;
                end
                else if (cnt_q != '0)
                begin
                    cnt_d = cnt_q - `SARCC_CNT_W'(1);
                end
                else
                begin
                    // [RULE4] back-to-back while held low
                    state_d = SARCC_CONV;
                    cnt_d = `SARCC_CNT_W'(`SARCC_CONV_CYC - 1);
                    busy_d = 1'b1;
                    lp_idle_d = 1'b0;
                end
            end
            default:
            begin
                state_d = SARCC_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    // static power and reference controls
    always_comb
    begin
        // [RULE11] reference source select
        iref_d = ~internal_ref_off_in;
        rbuf_d = ~ref_buffer_off_in;
        // [RULE10] interface enabled whenever chip select and read are both low, in any state
        ifen_d = ~(cs_n_in | rd_n_in);
        // full power-down follows busy one cycle late, so it takes effect outside a conversion and in its first busy cycle
        core_d = ~(full_powerdown_in & ~busy_q);
    end

    // register all state
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            start_prev_q <= 1'b1;
            state_q <= SARCC_IDLE;
            cnt_q <= '0;
            busy_q <= 1'b0;
            result_q <= `SARCC_SB_ZERO;
            valid_q <= 1'b0;
            lp_idle_q <= 1'b0;
            iref_q <= 1'b0;
            rbuf_q <= 1'b0;
            ifen_q <= 1'b0;
            core_q <= 1'b1;
        end
        else
        begin
            start_prev_q <= start_prev_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            result_q <= result_d;
            valid_q <= valid_d;
            lp_idle_q <= lp_idle_d;
            iref_q <= iref_d;
            rbuf_q <= rbuf_d;
            ifen_q <= ifen_d;
            core_q <= core_d;
        end
    end

    assign busy_out = busy_q;
    assign result_out = result_q;
    assign result_valid_out = valid_q;
    assign low_power_idle_out = lp_idle_q;
    assign int_ref_enable_out = iref_q;
    assign ref_buffer_enable_out = rbuf_q;
    assign interface_enable_out = ifen_q;
    assign core_powered_out = core_q;
endmodule

// ### test/sarcc_host.sv
// host side of the start line: idles high, pulses or holds it low on request
module sarcc_host
(
    input wire logic ref_clk_in,
    output logic conv_start_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial conv_start_n_out = 1'b1;
    task automatic drive(input logic lvl);
        @(posedge ref_clk_in);
        #5 conv_start_n_out = lvl;
    endtask
endmodule

// ### test/sarcc_top_checker.sv
module sarcc_top_checker
    import sarcc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic conv_start_n_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic [1:0] mode_in,
    input wire logic busy_out,
    input wire logic result_valid_out,
    input wire logic low_power_idle_out,
    input wire logic core_powered_out,
    input wire logic interface_enable_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [7:0] cnt_q; // busy cycles seen so far
    logic [7:0] cnt_d;
    wire logic lp = (mode_in == SARCC_LOWPWR);
    // count busy cycles, zero while idle
    always_comb
    begin
        cnt_d = busy_out ? cnt_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end
    // filtered start level is surely low after six low samples
    sequence held_low;
        (!conv_start_n_in)[*6];
    endsequence
    a_busy_holds: assert property (busy_out && cnt_q < 8'h1d |=> busy_out)
        else $error("busy dropped early");
    a_busy_ends: assert property (busy_out && cnt_q == 8'h1d |=> !busy_out)
        else $error("busy too long");
    a_valid_at_end: assert property ((result_valid_out || $fell(busy_out)) |->
        result_valid_out && $fell(busy_out)) else $error("valid not at busy fall");
    a_self_retrig: assert property (held_low ##0 ($fell(busy_out) && lp)
        ##1 (!conv_start_n_in)[*4] |=> $rose(busy_out)) else $error("no self restart");
    a_no_self_run: assert property (held_low ##0 ($fell(busy_out) && !lp)
        |=> (!busy_out)[*6]) else $error("restart outside low power");
    a_lp_idle: assert property ($fell(busy_out) && lp |-> low_power_idle_out)
        else $error("no reduced power");
    a_pd_blocked: assert property (busy_out && $past(busy_out) |-> core_powered_out)
        else $error("powered down in conversion");
    a_if_enable: assert property (!cs_n_in && !rd_n_in |=> interface_enable_out)
        else $error("interface off");
endmodule
bind sarcc_top sarcc_top_checker chk (.ref_clk_in, .reset_n_in, .conv_start_n_in, .cs_n_in,
    .rd_n_in, .mode_in, .busy_out, .result_valid_out, .low_power_idle_out, .core_powered_out,
    .interface_enable_out);

// ### test/sarcc_top_tb.sv
module sarcc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, cs_n = 1, rd_n = 1, pd = 0, iref_off = 0, rbuf_off = 0;
    logic fmt = 1, ov = 0, un = 0, busy, valid, lpi, iref_en, buf_en, if_en, core_on, start_n;
    logic [1:0] mode = 2'h0;
    logic [15:0] code = 16'h0000, result;
    logic [31:0] r;
    logic [15:0] exp_v; // expected static outputs, worked out from the driven pins
    int seed = 73606, mismatches = 0, n_compared = 0;
    // 20 MHz clock
    initial forever #25 clk = ~clk;
    sarcc_host host (.ref_clk_in(clk), .conv_start_n_out(start_n));
    sarcc_top dut (.ref_clk_in(clk), .reset_n_in(rst_n), .conv_start_n_in(start_n),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .full_powerdown_in(pd), .mode_in(mode),
        .internal_ref_off_in(iref_off), .ref_buffer_off_in(rbuf_off), .code_format_select_in(fmt),
        .sample_code_in(code), .sample_over_in(ov), .sample_under_in(un), .busy_out(busy),
        .result_out(result), .result_valid_out(valid), .low_power_idle_out(lpi),
        .int_ref_enable_out(iref_en), .ref_buffer_enable_out(buf_en),
        .interface_enable_out(if_en), .core_powered_out(core_on));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // step to just after an edge, where inputs change and outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // bounded wait for busy to reach a level
    task automatic wait_busy(input logic lvl);
        for (int k = 0; k < 40 && busy !== lvl; k++) tick(1);
        check({15'h0000, busy}, {15'h0000, lvl});
    endtask
    // saturation wins over the raw code, over before under; sign flip for twos complement
    function automatic logic [15:0] exp_code(input logic [15:0] c, input logic o, input logic u,
        input logic f);
        logic [15:0] v;
        v = o ? 16'hffff : (u ? 16'h0000 : c);
        return f ? v : v ^ 16'h8000;
    endfunction
    // one conversion with a second start while busy, and power-down raised while busy on odd runs and at random otherwise
    task automatic one_conv(input int i);
        logic [15:0] e;
        tick(i % 3);
        code = 16'($random(seed));
        r = $random(seed);
        // first half walks every format and clamp corner in fast mode; second half is random
        fmt = (i < 8) ? i[0] : r[0];
        ov = (i < 8) ? i[1] : r[1] & r[2];
        un = (i < 8) ? i[2] : r[3];
        // upper half runs normal mode or the spare code 3, which must behave as normal
        mode = {r[4] & i[3], i[3]};
        e = exp_code(code, ov, un, fmt);
        host.drive(1'b0);
        wait_busy(1'b1);
        host.drive(1'b1);
        tick(2);
        pd = r[5] | i[0];
        host.drive(1'b0);
        wait_busy(1'b0);
        check(result, e);
        check({15'h0000, valid}, 16'h0001);
        tick(10);
        check({14'h0000, busy, core_on}, {15'h0000, ~pd});
        pd = 1'b0;
        host.drive(1'b1);
        tick(6);
        $display("conversion %0d done", i);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #5 rst_n = 1'b1;
        // static pins: reference choice and interface gating, no start from them
        for (int j = 0; j < 6; j++)
        begin
            r = $random(seed);
            // four fixed reference combinations first, then two drawn at random
            iref_off = (j < 4) ? j[0] : r[2];
            rbuf_off = (j < 4) ? j[1] : r[3];
            cs_n = r[0];
            rd_n = r[1];
            tick(3);
            exp_v = {12'h000, ~iref_off, ~rbuf_off, ~(cs_n | rd_n), 1'b0};
            check({12'h000, iref_en, buf_en, if_en, busy}, exp_v);
        end
        $display("static pins done");
        // first start after power-up; its fast-mode result is thrown away
        host.drive(1'b0);
        wait_busy(1'b1);
        host.drive(1'b1);
        wait_busy(1'b0);
        $display("warm-up conversion done");
        for (int i = 0; i < 16; i++) one_conv(i);
        // low-power self run with the start line held low
        mode = 2'h2;
        cs_n = 1'b0;
        rd_n = 1'b0;
        host.drive(1'b0);
        for (int k = 0; k < 3; k++)
        begin
            wait_busy(1'b1);
            wait_busy(1'b0);
            check({14'h0000, lpi, if_en}, 16'h0003);
        end
        wait_busy(1'b1);
        host.drive(1'b1);
        wait_busy(1'b0);
        tick(12);
        check({14'h0000, busy, lpi}, 16'h0001);
        $display("self-run done");
        complete_run();
    end
    // watchdog: the full run needs well under 3000 cycles
    initial
    begin
        #300000;
        mismatches++;
        complete_run();
    end
endmodule
